// *** design/gdc_pkg.sv ***
package gdc_pkg;

    // Clock and time units
    localparam int CLK_PERIOD_NS = 10;
    localparam int NS_PER_US     = 1000;
    localparam int US_PER_MS     = 1000;

    // Serial frame layout: read flag, address, data
    localparam int REG_W       = 11;
    localparam int ADDR_W      = 4;
    localparam int FRAME_W     = 16;
    localparam int CNT_W       = 5;
    localparam int RW_BIT      = 15;
    localparam int ADDR_LSB    = 11;
    localparam int DATA_START  = 5;

    // Register offsets
    localparam logic [3:0] ADDR_DRIVER_CONTROL    = 4'h2;
    localparam logic [3:0] ADDR_HIGH_SIDE_GATE    = 4'h3;
    localparam logic [3:0] ADDR_LOW_SIDE_GATE     = 4'h4;
    localparam logic [3:0] ADDR_OVERCURRENT_CTRL  = 4'h5;

    // Field positions
    localparam int DRV_CLEAR_BIT   = 0;
    localparam int LOCK_LSB        = 8;
    localparam int LS_CBC_BIT      = 10;
    localparam int LS_PEAK_CURRENT_HOLD_TIME_LSB   = 8;
    localparam int LS_SOURCE_LSB   = 4;
    localparam int LS_SINK_LSB     = 0;
    localparam int OCP_RETRY_BIT   = 10;
    localparam int OCP_DEAD_LSB    = 8;
    localparam int OVERCURRENT_RESPONSE_POLICY_LSB    = 6;
    localparam int OVERCURRENT_FILTER_TIME_LSB     = 4;
    localparam int OCP_VDS_LSB     = 0;

    // Bits of driver control that stay writable while locked (clear strobe never stored)
    localparam logic [10:0] DRV_LOCKED_MASK = 11'h006;
    localparam logic [10:0] DRV_STORE_MASK  = 11'h7fe;
    localparam logic [10:0] HS_LOW_MASK     = 11'h0ff;

    // Reset values
    localparam logic [10:0] DRV_RESET = 11'h000;
    localparam logic [10:0] HS_RESET  = 11'h3ff;
    localparam logic [10:0] LS_RESET  = 11'h7ff;
    localparam logic [10:0] OCP_RESET = 11'h159;

    // Lock codes
    localparam logic [2:0] LOCK_ENGAGE  = 3'h6;
    localparam logic [2:0] LOCK_RELEASE = 3'h3;

    // Times as printed and derived cycle counts
    localparam int PEAK_BASE_NS    = 500;
    localparam int DEAD_BASE_NS    = 50;
    localparam int DEG_STEP_US     = 2;
    localparam int RETRY_LONG_MS   = 4;
    localparam int RETRY_SHORT_US  = 50;
    localparam int PEAK_BASE_CYC   = (PEAK_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEAD_BASE_CYC   = (DEAD_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEG_STEP_CYC    = (DEG_STEP_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RETRY_LONG_CYC  = RETRY_LONG_MS * US_PER_MS * NS_PER_US / CLK_PERIOD_NS;
    localparam int RETRY_SHORT_CYC = RETRY_SHORT_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int RETRY_CNT_W     = 19;
    localparam int DEG_CNT_W       = 10;

    // Strength tables in mA and threshold table in mV
    localparam logic [9:0] SOURCE_MA [16] = '{10'h00a, 10'h01e, 10'h03c, 10'h050, 10'h078, 10'h08c,
        10'h0aa, 10'h0be, 10'h104, 10'h14a, 10'h172, 10'h1b8, 10'h23a, 10'h2a8, 10'h334, 10'h3e8};
    localparam logic [10:0] SINK_MA [16] = '{11'h014, 11'h03c, 11'h078, 11'h0a0, 11'h0f0, 11'h118,
        11'h154, 11'h17c, 11'h208, 11'h294, 11'h2e4, 11'h370, 11'h474, 11'h550, 11'h668, 11'h7d0};
    localparam logic [10:0] VDS_MV [16] = '{11'h03c, 11'h082, 11'h0c8, 11'h104, 11'h136, 11'h1c2,
        11'h212, 11'h258, 11'h2a8, 11'h2ee, 11'h3ac, 11'h46a, 11'h514, 11'h5dc, 11'h6a4, 11'h758};

    typedef enum logic [1:0] {
        OCP_LATCH  = 2'b00,
        OCP_RETRY  = 2'b01,
        OCP_REPORT = 2'b10,
        OCP_OFF    = 2'b11
    } gdc_policy_t;

    typedef enum logic [1:0] {
        OC_IDLE     = 2'b00,
        OC_LATCHED  = 2'b01,
        OC_RETRYING = 2'b10,
        OC_REPORTED = 2'b11
    } gdc_oc_state_t;

    // Deglitch length: 2, 4, 6, 8 us
    function automatic logic [9:0] deg_cycles(input logic [1:0] code);
        deg_cycles = 10'(DEG_STEP_CYC * (int'(code) + 1));
    endfunction

    // Shared power-of-two timing decode
    function automatic logic [9:0] doubled(input int base, input logic [1:0] code);
        doubled = 10'(base << code);
    endfunction

endpackage

// *** design/gdc_spi_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module gdc_spi_port
    import gdc_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    // Serial pins
    input  wire logic              sclk_i,
    input  wire logic              cs_n_i,
    input  wire logic              sdi_i,
    output logic                   sdo_o,
    output logic                   sdo_oe_o,
    // Register side
    input  wire logic [REG_W-1:0]  rdata_i,
    output logic [ADDR_W-1:0]      addr_o,
    output logic                   wr_stb_o,
    output logic [REG_W-1:0]       wdata_o
);
    logic               sclk_prev, next_sclk_prev;
    logic [CNT_W-1:0]   bit_cnt, next_bit_cnt;
    logic [FRAME_W-1:0] shift_in, next_shift_in;
    logic [REG_W-1:0]   shift_out, next_shift_out;
    logic               load_pend, next_load_pend;
    logic               next_sdo, next_sdo_oe, next_wr_stb;
    logic [ADDR_W-1:0]  next_addr;
    logic [REG_W-1:0]   next_wdata;
    logic [FRAME_W-1:0] full;
    logic               fall, rise;

    // Sclk is oversampled, so each phase must last at least two clk cycles
    always_comb begin
        fall           = sclk_prev & ~sclk_i;
        rise           = ~sclk_prev & sclk_i;
        full           = {shift_in[FRAME_W-2:0], sdi_i};
        next_sclk_prev = sclk_i;
        next_bit_cnt   = bit_cnt;
        next_shift_in  = shift_in;
        next_shift_out = shift_out;
        next_load_pend = 1'b0;
        next_sdo       = sdo_o;
        next_sdo_oe    = ~cs_n_i;
        next_wr_stb    = 1'b0;
        next_addr      = addr_o;
        next_wdata     = wdata_o;
        if (cs_n_i) begin
            next_bit_cnt = '0;
            next_sdo     = 1'b0;
        end else begin
            if (load_pend) begin
                next_shift_out = rdata_i;
            end
            if (fall && bit_cnt < CNT_W'(FRAME_W)) begin
                next_shift_in = full;
                next_bit_cnt  = bit_cnt + 1'b1;
                if (bit_cnt == CNT_W'(DATA_START - 1)) begin
                    next_addr      = full[ADDR_W-1:0];
                    next_load_pend = 1'b1;
                end
                if (bit_cnt == CNT_W'(FRAME_W - 1) && !full[RW_BIT]) begin
                    next_addr   = full[ADDR_LSB +: ADDR_W];
                    next_wdata  = full[REG_W-1:0];
                    next_wr_stb = 1'b1;
                end
            end
            if (rise && bit_cnt >= CNT_W'(DATA_START) && bit_cnt < CNT_W'(FRAME_W)) begin
                next_sdo       = shift_out[REG_W-1];
                next_shift_out = {shift_out[REG_W-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sclk_prev <= 1'b0;
            bit_cnt   <= '0;
            shift_in  <= '0;
            shift_out <= '0;
            load_pend <= 1'b0;
            sdo_o     <= 1'b0;
            sdo_oe_o  <= 1'b0;
            wr_stb_o  <= 1'b0;
            addr_o    <= '0;
            wdata_o   <= '0;
        end else begin
            sclk_prev <= next_sclk_prev;
            bit_cnt   <= next_bit_cnt;
            shift_in  <= next_shift_in;
            shift_out <= next_shift_out;
            load_pend <= next_load_pend;
            sdo_o     <= next_sdo;
            sdo_oe_o  <= next_sdo_oe;
            wr_stb_o  <= next_wr_stb;
            addr_o    <= next_addr;
            wdata_o   <= next_wdata;
        end
    end
endmodule
`default_nettype wire

// *** design/gdc_config_regs.sv ***
//
// Contract
// RQ1 - Per-cycle enable plus retry: PWM pulse clears faults
// RQ2 - Peak hold time 500/1000/2000/4000 ns
// RQ3 - Low gate source 10 to 1000 mA
// RQ4 - Low gate sink 20 to 2000 mA
// RQ5 - One retry interval: 4 ms or 50 us
// RQ6 - Dead time 50/100/200/400 ns
// RQ7 - Policy 00b: latched until cleared
// RQ8 - Policy 01b: self-clearing retry fault
// RQ9 - Policy 10b: report only, no gate action
// RQ10 - Policy 11b: no report, no action
// RQ11 - Overcurrent must persist 2/4/6/8 us
// RQ12 - Trip threshold 0.06 to 1.88 V
// RQ13 - Lock code 110b blocks writes; 011b unlocks (code still writes driver control bits 2:1 and clear when locked)
// RQ14 - Fault clear bit clears, self-resets
// RQ15 - Retry fault clears after retry interval
//
`timescale 1ns/1ps
`default_nettype none
module gdc_config_regs
    import gdc_pkg::*;
#(
    parameter int RETRY_LONG_CYCLES  = RETRY_LONG_CYC,
    parameter int RETRY_SHORT_CYCLES = RETRY_SHORT_CYC
)(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    // Serial register port
    input  wire logic        spi_sclk_i,
    input  wire logic        spi_cs_n_i,
    input  wire logic        spi_sdi_i,
    output logic             spi_sdo_o,
    output logic             spi_sdo_oe_o,
    // Gate inputs and overcurrent comparators
    input  wire logic        pwm_i,
    input  wire logic        vds_overcurrent_i,
    input  wire logic        sense_overcurrent_i,
    // Fault and lock state
    output logic             drain_source_overcurrent_fault_o,
    output logic             sense_overcurrent_fault_o,
    output logic             gate_shutdown_o,
    output logic             registers_locked_o,
    // Decoded drive settings
    output logic             per_cycle_fault_clear_enable_o,
    output logic [9:0]       peak_current_hold_cycles_o,
    output logic [9:0]       low_gate_source_strength_o,
    output logic [10:0]      low_gate_sink_strength_o,
    output logic [9:0]       dead_time_cycles_o,
    output logic [9:0]       overcurrent_filter_cycles_o,
    output logic [10:0]      drain_source_trip_threshold_o
);
    logic [REG_W-1:0]       drv_ctrl, next_drv_ctrl;
    logic [REG_W-1:0]       hs_ctrl, next_hs_ctrl;
    logic [REG_W-1:0]       ls_ctrl, next_ls_ctrl;
    logic [REG_W-1:0]       ocp_ctrl, next_ocp_ctrl;
    logic [REG_W-1:0]       rdata;
    logic [ADDR_W-1:0]      addr;
    logic [REG_W-1:0]       wdata;
    logic                   wr_stb;
    logic                   locked;
    logic                   clear_req;

    gdc_spi_port u_spi (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .sclk_i   (spi_sclk_i),
        .cs_n_i   (spi_cs_n_i),
        .sdi_i    (spi_sdi_i),
        .sdo_o    (spi_sdo_o),
        .sdo_oe_o (spi_sdo_oe_o),
        .rdata_i  (rdata),
        .addr_o   (addr),
        .wr_stb_o (wr_stb),
        .wdata_o  (wdata)
    );

    // Register writes and lock handling
    always_comb begin
        locked        = (hs_ctrl[LOCK_LSB +: 3] == LOCK_ENGAGE);
        next_drv_ctrl = drv_ctrl;
        next_hs_ctrl  = hs_ctrl;
        next_ls_ctrl  = ls_ctrl;
        next_ocp_ctrl = ocp_ctrl;
        clear_req     = 1'b0;
        if (wr_stb) begin
            case (addr)
                ADDR_DRIVER_CONTROL: begin
                    // Clear strobe acts at once and is never stored, so it reads back zero
                    clear_req = wdata[DRV_CLEAR_BIT]; // [RQ14]
                    if (locked) begin
                        next_drv_ctrl = (drv_ctrl & ~DRV_LOCKED_MASK) | (wdata & DRV_LOCKED_MASK); // [RQ13]
                    end else begin
                        next_drv_ctrl = wdata & DRV_STORE_MASK;
                    end
                end
                ADDR_HIGH_SIDE_GATE: begin
                    if (!locked && wdata[LOCK_LSB +: 3] == LOCK_ENGAGE) begin
                        next_hs_ctrl[LOCK_LSB +: 3] = LOCK_ENGAGE; // [RQ13]
                    end
                    if (locked && wdata[LOCK_LSB +: 3] == LOCK_RELEASE) begin
                        next_hs_ctrl[LOCK_LSB +: 3] = LOCK_RELEASE; // [RQ13]
                    end
                    if (!locked) begin
                        next_hs_ctrl = (next_hs_ctrl & ~HS_LOW_MASK) | (wdata & HS_LOW_MASK);
                    end
                end
                ADDR_LOW_SIDE_GATE: begin
                    if (!locked) begin
                        next_ls_ctrl = wdata; // [RQ13]
                    end
                end
                ADDR_OVERCURRENT_CTRL: begin
                    if (!locked) begin
                        next_ocp_ctrl = wdata; // [RQ13]
                    end
                end
                default: begin
                end
            endcase
        end
        case (addr)
            ADDR_DRIVER_CONTROL:   rdata = drv_ctrl;
            ADDR_HIGH_SIDE_GATE:   rdata = hs_ctrl;
            ADDR_LOW_SIDE_GATE:    rdata = ls_ctrl;
            ADDR_OVERCURRENT_CTRL: rdata = ocp_ctrl;
            default:               rdata = '0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            drv_ctrl <= DRV_RESET;
            hs_ctrl  <= HS_RESET;
            ls_ctrl  <= LS_RESET;
            ocp_ctrl <= OCP_RESET;
        end else begin
            drv_ctrl <= next_drv_ctrl;
            hs_ctrl  <= next_hs_ctrl;
            ls_ctrl  <= next_ls_ctrl;
            ocp_ctrl <= next_ocp_ctrl;
        end
    end

    // Overcurrent handling, channel 0 drain-source, channel 1 sense
    gdc_policy_t            policy;
    gdc_oc_state_t          state [2];
    gdc_oc_state_t          next_state [2];
    logic [DEG_CNT_W-1:0]   deg_cnt [2];
    logic [DEG_CNT_W-1:0]   next_deg_cnt [2];
    logic [RETRY_CNT_W-1:0] retry_cnt [2];
    logic [RETRY_CNT_W-1:0] next_retry_cnt [2];
    logic [1:0]             raw;
    logic [1:0]             detect;
    logic [1:0]             release_now;
    logic [DEG_CNT_W-1:0]   deg_target;
    logic [RETRY_CNT_W-1:0] retry_last;
    logic                   pwm_prev, next_pwm_prev;
    logic                   pwm_rise;
    logic                   cbc;
    logic                   next_vds_flag, next_sen_flag, next_shutdown;
    gdc_oc_state_t          fault_state;

    always_comb begin
        policy        = gdc_policy_t'(ocp_ctrl[OVERCURRENT_RESPONSE_POLICY_LSB +: 2]);
        raw           = {sense_overcurrent_i, vds_overcurrent_i};
        cbc           = ls_ctrl[LS_CBC_BIT];
        pwm_rise      = pwm_i & ~pwm_prev;
        next_pwm_prev = pwm_i;
        deg_target    = deg_cycles(ocp_ctrl[OVERCURRENT_FILTER_TIME_LSB +: 2]); // [RQ11]
        // Both channels share one interval
        retry_last    = ocp_ctrl[OCP_RETRY_BIT] ? RETRY_CNT_W'(RETRY_SHORT_CYCLES - 1)
                                                : RETRY_CNT_W'(RETRY_LONG_CYCLES - 1); // [RQ5]
        case (policy)
            OCP_LATCH:  fault_state = OC_LATCHED; // [RQ7]
            OCP_RETRY:  fault_state = OC_RETRYING; // [RQ8]
            OCP_REPORT: fault_state = OC_REPORTED; // [RQ9]
            default:    fault_state = OC_IDLE; // [RQ10]
        endcase
        for (int ch = 0; ch < 2; ch++) begin
            // Saturating counter: condition must hold deg_target consecutive cycles
            detect[ch] = raw[ch] && (deg_cnt[ch] >= deg_target - 1'b1); // [RQ11]
            if (!raw[ch]) begin
                next_deg_cnt[ch] = '0;
            end else if (deg_cnt[ch] < deg_target - 1'b1) begin
                next_deg_cnt[ch] = deg_cnt[ch] + 1'b1;
            end else begin
                next_deg_cnt[ch] = deg_cnt[ch];
            end
            release_now[ch] = clear_req; // [RQ14]
            if (state[ch] == OC_RETRYING) begin
                if (retry_cnt[ch] >= retry_last) begin
                    release_now[ch] = 1'b1; // [RQ15]
                end
                if (cbc && pwm_rise) begin
                    release_now[ch] = 1'b1; // [RQ1]
                end
            end
            // A new detection wins over any clear in the same cycle
            if (detect[ch] && policy != OCP_OFF) begin
                next_state[ch] = fault_state;
            end else if (release_now[ch]) begin
                next_state[ch] = OC_IDLE;
            end else begin
                next_state[ch] = state[ch];
            end
            if (next_state[ch] == OC_RETRYING && state[ch] == OC_RETRYING && !release_now[ch]) begin
                next_retry_cnt[ch] = retry_cnt[ch] + 1'b1; // [RQ15]
            end else begin
                next_retry_cnt[ch] = '0;
            end
        end
        next_vds_flag = (next_state[0] != OC_IDLE);
        next_sen_flag = (next_state[1] != OC_IDLE);
        // Report-only keeps the gates running
        next_shutdown = 1'b0;
        for (int ch = 0; ch < 2; ch++) begin
            if (next_state[ch] == OC_LATCHED || next_state[ch] == OC_RETRYING) begin
                next_shutdown = 1'b1; // [RQ7] [RQ8] [RQ9]
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pwm_prev                         <= 1'b0;
            drain_source_overcurrent_fault_o <= 1'b0;
            sense_overcurrent_fault_o        <= 1'b0;
            gate_shutdown_o                  <= 1'b0;
            for (int ch = 0; ch < 2; ch++) begin
                state[ch]     <= OC_IDLE;
                deg_cnt[ch]   <= '0;
                retry_cnt[ch] <= '0;
            end
        end else begin
            pwm_prev                         <= next_pwm_prev;
            drain_source_overcurrent_fault_o <= next_vds_flag;
            sense_overcurrent_fault_o        <= next_sen_flag;
            gate_shutdown_o                  <= next_shutdown;
            for (int ch = 0; ch < 2; ch++) begin
                state[ch]     <= next_state[ch];
                deg_cnt[ch]   <= next_deg_cnt[ch];
                retry_cnt[ch] <= next_retry_cnt[ch];
            end
        end
    end

    // Decoded settings, one cycle behind the registers
    logic        next_cbc_out;
    logic [9:0]  next_peak, next_source, next_dead, next_filter;
    logic [10:0] next_sink, next_thresh;

    always_comb begin
        next_cbc_out = ls_ctrl[LS_CBC_BIT];
        next_peak    = doubled(PEAK_BASE_CYC, ls_ctrl[LS_PEAK_CURRENT_HOLD_TIME_LSB +: 2]); // [RQ2]
        next_source  = SOURCE_MA[ls_ctrl[LS_SOURCE_LSB +: 4]]; // [RQ3]
        next_sink    = SINK_MA[ls_ctrl[LS_SINK_LSB +: 4]]; // [RQ4]
        next_dead    = doubled(DEAD_BASE_CYC, ocp_ctrl[OCP_DEAD_LSB +: 2]); // [RQ6]
        next_filter  = deg_target; // [RQ11]
        next_thresh  = VDS_MV[ocp_ctrl[OCP_VDS_LSB +: 4]]; // [RQ12]
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            registers_locked_o             <= 1'b0;
            per_cycle_fault_clear_enable_o <= 1'b0;
            peak_current_hold_cycles_o     <= '0;
            low_gate_source_strength_o     <= '0;
            low_gate_sink_strength_o       <= '0;
            dead_time_cycles_o             <= '0;
            overcurrent_filter_cycles_o    <= '0;
            drain_source_trip_threshold_o  <= '0;
        end else begin
            registers_locked_o             <= locked;
            per_cycle_fault_clear_enable_o <= next_cbc_out;
            peak_current_hold_cycles_o     <= next_peak;
            low_gate_source_strength_o     <= next_source;
            low_gate_sink_strength_o       <= next_sink;
            dead_time_cycles_o             <= next_dead;
            overcurrent_filter_cycles_o    <= next_filter;
            drain_source_trip_threshold_o  <= next_thresh;
        end
    end
endmodule
`default_nettype wire

// *** testbench/gdc_config_regs_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module gdc_config_regs_sva (
    input wire logic        clk_i,
    input wire logic        reset_i,
    input wire logic        spi_cs_n_i,
    input wire logic        spi_sdo_o,
    input wire logic        spi_sdo_oe_o,
    input wire logic        vds_overcurrent_i,
    input wire logic        drain_source_overcurrent_fault_o,
    input wire logic        sense_overcurrent_fault_o,
    input wire logic        gate_shutdown_o,
    input wire logic        registers_locked_o,
    input wire logic        per_cycle_fault_clear_enable_o,
    input wire logic [9:0]  peak_current_hold_cycles_o,
    input wire logic [9:0]  dead_time_cycles_o,
    input wire logic [9:0]  overcurrent_filter_cycles_o,
    input wire logic [10:0] drain_source_trip_threshold_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // High run
    logic [9:0] high_run;
    logic [9:0] next_high_run;
    always_comb next_high_run = !vds_overcurrent_i ? 10'h000 : high_run + 10'(high_run != 10'h3ff);
    always_ff @(posedge clk_i) high_run <= reset_i ? 10'h000 : next_high_run;

    oe_follow_a: assert property (!$past(reset_i) |-> spi_sdo_oe_o == !$past(spi_cs_n_i))
        else $error("sdo enable lag");
    sdo_idle_a: assert property (spi_cs_n_i [*2] |-> !spi_sdo_o)
        else $error("sdo busy idle");
    shut_needs_a: assert property (gate_shutdown_o |-> drain_source_overcurrent_fault_o || sense_overcurrent_fault_o)
        else $error("shutdown no flag");
    shut_rise_a: assert property ($rose(gate_shutdown_o) |-> $rose(drain_source_overcurrent_fault_o) || $rose(sense_overcurrent_fault_o))
        else $error("shutdown no fault");
    filter_wait_a: assert property ($rose(drain_source_overcurrent_fault_o) |-> high_run >= overcurrent_filter_cycles_o)
        else $error("fault too early");
    hold_codes_a: assert property (!$past(reset_i) |=> peak_current_hold_cycles_o inside {10'd50, 10'd100, 10'd200, 10'd400})
        else $error("bad hold");
    dead_codes_a: assert property (!$past(reset_i) |=> dead_time_cycles_o inside {10'd5, 10'd10, 10'd20, 10'd40})
        else $error("bad dead");
    filt_codes_a: assert property (!$past(reset_i) |=> overcurrent_filter_cycles_o inside {10'd200, 10'd400, 10'd600, 10'd800})
        else $error("bad filter");
    cfg_quiet_a: assert property (spi_cs_n_i [*6] |-> $stable(drain_source_trip_threshold_o) && $stable(per_cycle_fault_clear_enable_o))
        else $error("idle change");

    cover property ($rose(drain_source_overcurrent_fault_o));
    cover property ($fell(sense_overcurrent_fault_o));
    cover property ($rose(registers_locked_o));
endmodule
bind gdc_config_regs gdc_config_regs_sva u_sva (.*);
`default_nettype wire

// *** testbench/gdc_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module gdc_ctrl_model (
    input  wire logic clk_i,
    input  wire logic sdo_i,
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      sdi_o,
    output logic      pwm_o
);
    int ph = 5;
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o = 1'b0;
        pwm_o = 1'b0;
    end
    // Idle data toggles so a stale bit shows
    always @(posedge clk_i) if (cs_n_o) sdi_o <= ~sdi_o;
    task automatic xfer(input logic [15:0] f, output logic [10:0] rd);
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            @(posedge clk_i);
            sdi_o <= f[i];
            sclk_o <= 1'b1;
            repeat (ph) @(posedge clk_i);
            if (i <= 10) rd[i] = sdo_i;
            sclk_o <= 1'b0;
            repeat (ph - 1) @(posedge clk_i);
        end
        repeat (6) @(posedge clk_i);
        cs_n_o <= 1'b1;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic pulse();
        @(posedge clk_i);
        pwm_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        pwm_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import gdc_pkg::*;
    logic             clk_i = 1'b0;
    logic             reset_i = 1'b1;
    logic             vds_i = 1'b0;
    logic             sen_i = 1'b0;
    wire logic        sclk, cs_n, sdi, sdo, sdo_oe, pwm, f_ds, f_sn, shut, lckd, cbc;
    wire logic [9:0]  hold, src_ma, dead, filt;
    wire logic [10:0] snk_ma, thr_mv;
    logic [10:0]      rg [16];
    logic             lk = 1'b0;
    int               fails = 0, checks = 0, cyc = 0, n, e;
    int src [16] = '{10,30,60,80,120,140,170,190,260,330,370,440,570,680,820,1000};
    int snk [16] = '{20,60,120,160,240,280,340,380,520,660,740,880,1140,1360,1640,2000};
    int thr [16] = '{60,130,200,260,310,450,530,600,680,750,940,1130,1300,1500,1700,1880};

    gdc_ctrl_model ctrl (.clk_i, .sdo_i(sdo), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .pwm_o(pwm));
    gdc_config_regs #(.RETRY_LONG_CYCLES(40), .RETRY_SHORT_CYCLES(10)) dut (
        .clk_i, .reset_i, .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_sdi_i(sdi),
        .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe), .pwm_i(pwm), .vds_overcurrent_i(vds_i),
        .sense_overcurrent_i(sen_i), .drain_source_overcurrent_fault_o(f_ds), .sense_overcurrent_fault_o(f_sn),
        .gate_shutdown_o(shut), .registers_locked_o(lckd), .per_cycle_fault_clear_enable_o(cbc),
        .peak_current_hold_cycles_o(hold), .low_gate_source_strength_o(src_ma),
        .low_gate_sink_strength_o(snk_ma), .dead_time_cycles_o(dead), .overcurrent_filter_cycles_o(filt),
        .drain_source_trip_threshold_o(thr_mv));

    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            close_out();
        end
    end

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
        checks++;
        if (x !== s) begin
            fails++;
            $display("[FAIL] %s expected %0h seen %0h", nm, x, s);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [10:0] d);
        logic [10:0] r;
        ctrl.xfer({1'b0, a, d}, r);
        if (a == 4'h2) rg[2] = lk ? (rg[2] & 11'h7f9) | (d & 11'h006) : d & 11'h7fe;
        if (!lk && (a == 4'h4 || a == 4'h5)) rg[a] = d;
        if (!lk && a == 4'h3) rg[3][7:0] = d[7:0];
        if (a == 4'h3 && d[10:8] == (lk ? 3'h3 : 3'h6)) lk = !lk;
        rg[3][10:8] = lk ? 3'h6 : 3'h3;
    endtask
    task automatic rd_chk(input logic [3:0] a);
        logic [10:0] r;
        ctrl.xfer({1'b1, a, 11'h000}, r);
        chk($sformatf("reg%0h", a), rg[a], r);
    endtask
    task automatic chk_dec();
        chk("cbc", rg[4][10], cbc);
        chk("hold", 50 << rg[4][9:8], hold);
        chk("source", src[rg[4][7:4]], src_ma);
        chk("sink", snk[rg[4][3:0]], snk_ma);
        chk("dead", 5 << rg[5][9:8], dead);
        chk("filter", 200 * (rg[5][5:4] + 1), filt);
        chk("threshold", thr[rg[5][3:0]], thr_mv);
    endtask
    task automatic trip(input bit s);
        @(posedge clk_i);
        if (s) sen_i <= 1'b1;
        else vds_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (!(s ? f_sn : f_ds) && n < 300);
        vds_i <= 1'b0;
        sen_i <= 1'b0;
    endtask
    task automatic close_out();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        rg = '{3: 11'h3ff, 4: 11'h7ff, 5: 11'h159, default: 11'h000};
        void'($urandom(32'h83be5ae4));
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        for (int a = 0; a < 10; a++) rd_chk(4'(a));
        chk_dec();
        wr(4'h9, 11'h5a5);
        rd_chk(4'h9);
        for (int i = 0; i < 10; i++) begin
            ctrl.ph = 5 + 3 * (i % 2);
            wr(4'h4, 11'($urandom));
            wr(4'h5, 11'($urandom));
            rd_chk(4'h4);
            rd_chk(4'h5);
            chk_dec();
        end
        ctrl.ph = 5;
        for (int k = 0; k < 8; k++) begin
            wr(4'h4, 11'h3ff);
            wr(4'h5, {k[2], 2'b00, k[1:0], 6'h09});
            trip(k[0]);
            chk("filter_wait", 1, n >= 201 && n <= 203 || k[1:0] == 2'd3);
            chk("flag", k[1:0] != 2'd3, k[0] ? f_sn : f_ds);
            chk("shutdown", k[1:0] < 2'd2, shut);
            n = 0;
            while ((k[0] ? f_sn : f_ds) && n < 100) begin
                @(posedge clk_i);
                n++;
            end
            e = k[1:0] == 2'd1 ? (k[2] ? 10 : 40) : (k[1:0] == 2'd3 ? 0 : 100);
            chk("fault_len", 1, n >= e - 2 && n <= e + 2);
            wr(4'h2, 11'h001);
            chk("cleared", 0, f_ds | f_sn | shut);
            rd_chk(4'h2);
        end
        wr(4'h4, 11'h7ff);
        wr(4'h5, 11'h049);
        sen_i <= 1'b1;
        trip(1'b0);
        ctrl.pulse();
        chk("pulse_clear", 0, f_ds | f_sn);
        wr(4'h3, {3'h6, rg[3][7:0]});
        chk("locked", 1, lckd);
        wr(4'h5, 11'h2aa);
        wr(4'h4, 11'h155);
        wr(4'h2, 11'h7fe);
        wr(4'h3, {3'h5, 8'h12});
        for (int a = 2; a < 6; a++) rd_chk(4'(a));
        chk_dec();
        wr(4'h3, {3'h3, rg[3][7:0]});
        wr(4'h5, 11'h2aa);
        rd_chk(4'h5);
        chk("unlocked", 0, lckd);
        close_out();
    end
endmodule
`default_nettype wire
